// *** progressive_clock_ramp_defs.vh ***
// register map, field positions and reset values for the progressive clock ramp
// assumes a 32-bit plain register port with byte addresses, one word per register
`ifndef PROGRESSIVE_CLOCK_RAMP_DEFS_VH
`define PROGRESSIVE_CLOCK_RAMP_DEFS_VH

// ==========================================================
// register offsets
`define A_STEP_DUR      8'h00
`define A_MODE_CTRL     8'h04
`define A_STATUS        8'h08
`define A_CUR_DIV       8'h0c
`define A_PROG_DONE     8'h50
`define A_MODE_CFG_BASE 8'h10
`define A_CHANGE_BASE   8'h20
`define A_START_BASE    8'h30
`define A_END_BASE      8'h40
`define A_GROUP_MASK    8'hf0
`define A_INDEX_LSB     2

// ==========================================================
// field positions
`define F_MODE_SEL      1:0
`define F_LEVEL         2:0
`define F_CFG_SRC       5:4
`define F_CFG_CORE      8
`define F_RATE          15:0
`define F_INIT          31:16
`define F_DIV           15:0
`define F_SDUR          7:0

// ==========================================================
// reset values and constants
`define SDUR_RST        8'h10
`define DIV_UNITY       16'h03e7
`define SRC_INTERNAL    2'h0
`define MODE_DEFAULT    2'h0
`define REF_MHZ         16
`define CLK_MHZ         50

`endif

// *** frac_tick_gen.v ***
// fractional tick generator: emits NUM pulses per DEN clocks, evenly spread
// assumes NUM < DEN and that the caller reads o_tick as a one-cycle enable
`timescale 1ns/1ps

module frac_tick_gen #(
    parameter NUM = 16,
    parameter DEN = 50,
    parameter AW  = 8
) (
    input  wire          i_clk,
    input  wire          i_rst,
    output reg           o_tick
);

    localparam [AW-1:0] STEP_NUM = NUM[AW-1:0];
    localparam [AW-1:0] STEP_DEN = DEN[AW-1:0];

    reg  [AW-1:0] acc_q;
    wire [AW-1:0] acc_sum;

    assign acc_sum = acc_q + STEP_NUM;

    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            acc_q  <= {AW{1'b0}};
            o_tick <= 1'b0;
        end
        else if (acc_sum >= STEP_DEN)
        begin
            acc_q  <= acc_sum - STEP_DEN;
            o_tick <= 1'b1;
        end
        else
        begin
            acc_q  <= acc_sum;
            o_tick <= 1'b0;
        end
    end

endmodule // frac_tick_gen

// *** progressive_clock_ramp.v ***
// progressive clock ramp controller: steps the system clock divider on mode change
// assumes one 50 MHz clock, a plain register port and a pin-level warm reset request
//
// What this block does
// - power-on reset selects internal oscillator
// - differing power level triggers stepped ramp
// - same-mode entry ramps if level changed
// - ramp-down uses current source settings
// - ramp-up uses target source settings
// - step lasts step-duration reference clocks
// - first increment starts the ramp
// - start divider begins ramp-up
// - end divider ends ramp-down
// - cores enabled at low frequency on a level change; equal-level entry enables them at once at unity divider
// - warm reset while idle ramps back to oscillator when programmed, else switches at once
`timescale 1ns/1ps
`include "progressive_clock_ramp_defs.vh"

module progressive_clock_ramp #(
    parameter NSRC = 4,
    parameter NMODE = 4
) (
    input  wire        i_clk,
    input  wire        i_rst,
    input  wire [7:0]  i_addr,
    input  wire [31:0] i_wdata,
    input  wire        i_wr,
    input  wire        i_rd,
    output reg  [31:0] o_rdata,
    input  wire        i_warm_reset,
    output wire [1:0]  o_sys_src,
    output wire [15:0] o_sys_div,
    output wire [1:0]  o_cur_mode,
    output wire        o_core_en,
    output wire        o_ramp_busy
);

    // ==========================================================
    // states
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_DOWN = 2'h1;
    localparam [1:0] ST_SWITCH = 2'h2;
    localparam [1:0] ST_UP = 2'h3;

    // ==========================================================
    // address decode helper, used by both write and read paths
    function [2:0] group_of;
        input [7:0] addr;
        begin
            case (addr & `A_GROUP_MASK)
                `A_MODE_CFG_BASE: group_of = 3'h1;
                `A_CHANGE_BASE:   group_of = 3'h2;
                `A_START_BASE:    group_of = 3'h3;
                `A_END_BASE:      group_of = 3'h4;
                default:          group_of = 3'h0;
            endcase
        end
    endfunction

    wire [2:0] wr_grp;
    wire [2:0] rd_grp;
    wire [1:0] wr_idx;
    wire [1:0] rd_idx;

    assign wr_grp = group_of(i_addr);
    assign rd_grp = wr_grp;
    assign wr_idx = i_addr[`A_INDEX_LSB+1:`A_INDEX_LSB];
    assign rd_idx = wr_idx;

    // ==========================================================
    // software registers
    reg [7:0]  sdur_q;
    reg [31:0] mode_cfg_q [0:NMODE-1];
    reg [31:0] change_q   [0:NSRC-1];
    reg [15:0] start_q    [0:NSRC-1];
    reg [15:0] end_q      [0:NSRC-1];
    reg        prog_q;
    integer    k;

    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            sdur_q <= `SDUR_RST;
            prog_q <= 1'b0;
            for (k = 0; k < NMODE; k = k + 1)
            begin
                mode_cfg_q[k] <= 32'h0000_0000;
            end
            for (k = 0; k < NSRC; k = k + 1)
            begin
                change_q[k] <= 32'h0000_0000;
                start_q[k]  <= `DIV_UNITY;
                end_q[k]    <= `DIV_UNITY;
            end
        end
        else if (i_wr)
        begin
            if (i_addr == `A_STEP_DUR)
                sdur_q <= i_wdata[`F_SDUR];
            // settings count as programmed once software says so
            if (i_addr == `A_PROG_DONE)
                prog_q <= i_wdata[0];
            case (wr_grp)
                3'h1: mode_cfg_q[wr_idx] <= i_wdata;
                3'h2: change_q[wr_idx] <= i_wdata;
                3'h3: start_q[wr_idx] <= i_wdata[`F_DIV];
                3'h4: end_q[wr_idx] <= i_wdata[`F_DIV];
                default: ;
            endcase
        end
    end

    // ==========================================================
    // warm reset request from a pin: two flops, then edge detect
    reg wrst_s1_q;
    reg wrst_s2_q;
    reg wrst_s3_q;
    wire wrst_edge;

    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            wrst_s1_q <= 1'b0;
            wrst_s2_q <= 1'b0;
            wrst_s3_q <= 1'b0;
        end
        else
        begin
            wrst_s1_q <= i_warm_reset;
            wrst_s2_q <= wrst_s1_q;
            wrst_s3_q <= wrst_s2_q;
        end
    end

    assign wrst_edge = wrst_s2_q & ~wrst_s3_q;

    // ==========================================================
    // 16 MHz reference pacing derived from the 50 MHz clock
    wire ref_tick;

    frac_tick_gen #(
        .NUM (`REF_MHZ),
        .DEN (`CLK_MHZ),
        .AW  (8)
    ) u_ref_tick (
        .i_clk  (i_clk),
        .i_rst  (i_rst),
        .o_tick (ref_tick)
    );

    // ==========================================================
    // ramp state machine
    reg [1:0]  state_q;
    reg [1:0]  src_q;
    reg [15:0] div_q;
    reg [15:0] inc_q;
    reg [7:0]  cnt_q;
    reg [1:0]  cur_mode_q;
    reg [2:0]  cur_lvl_q;
    reg        core_en_q;
    reg [1:0]  tgt_mode_q;
    reg [1:0]  tgt_src_q;
    reg [2:0]  tgt_lvl_q;
    reg        tgt_core_q;

    wire [1:0]  req_mode;
    wire [31:0] req_cfg;
    wire [16:0] down_sum;
    wire [16:0] up_floor;
    wire        step_due;
    wire        mctl_wr;

    assign req_mode = i_wdata[`F_MODE_SEL];
    assign req_cfg  = mode_cfg_q[req_mode];
    assign mctl_wr  = i_wr & (i_addr == `A_MODE_CTRL);
    // ratio times thousand, increment added per step
    assign down_sum = {1'b0, div_q} + {1'b0, inc_q};
    assign up_floor = {1'b0, inc_q} + {1'b0, `DIV_UNITY};
    // step ends after step-duration reference ticks
    assign step_due = ref_tick & ((sdur_q == 8'h00) | (cnt_q + 8'h01 >= sdur_q));

    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            state_q    <= ST_IDLE;
            src_q      <= `SRC_INTERNAL;
            div_q      <= `DIV_UNITY;
            inc_q      <= 16'h0000;
            cnt_q      <= 8'h00;
            cur_mode_q <= `MODE_DEFAULT;
            cur_lvl_q  <= 3'h0;
            core_en_q  <= 1'b0;
            tgt_mode_q <= `MODE_DEFAULT;
            tgt_src_q  <= `SRC_INTERNAL;
            tgt_lvl_q  <= 3'h0;
            tgt_core_q <= 1'b0;
        end
        else
        begin
            if (state_q == ST_DOWN || state_q == ST_UP)
                cnt_q <= step_due ? 8'h00 : (ref_tick ? cnt_q + 8'h01 : cnt_q);
            else
                cnt_q <= 8'h00;
            case (state_q)
                ST_IDLE:
                begin
                    // warm reset outranks a mode write in the same cycle
                    if (wrst_edge)
                    begin
                        tgt_mode_q <= `MODE_DEFAULT;
                        tgt_src_q  <= `SRC_INTERNAL;
                        tgt_lvl_q  <= mode_cfg_q[0][`F_LEVEL];
                        tgt_core_q <= 1'b0;
                        // warm reset ramps back when programmed
                        if (prog_q && src_q != `SRC_INTERNAL)
                        begin
                            state_q <= ST_DOWN;
                            div_q   <= `DIV_UNITY;
                            inc_q   <= change_q[src_q][`F_RATE];
                        end
                        else
                        begin
                            state_q <= ST_SWITCH;
                        end
                    end
                    // mode control write starts a change
                    else if (mctl_wr)
                    begin
                        tgt_mode_q <= req_mode;
                        tgt_src_q  <= req_cfg[`F_CFG_SRC];
                        tgt_lvl_q  <= req_cfg[`F_LEVEL];
                        tgt_core_q <= req_cfg[`F_CFG_CORE];
                        // same mode with edited level differs too
                        if (req_cfg[`F_LEVEL] != cur_lvl_q && src_q != `SRC_INTERNAL)
                        begin
                            state_q <= ST_DOWN;
                            div_q   <= `DIV_UNITY;
                            inc_q   <= change_q[src_q][`F_RATE];
                        end
                        else if (req_cfg[`F_LEVEL] != cur_lvl_q)
                        begin
                            state_q <= ST_SWITCH;
                        end
                        else
                        begin
                            // equal levels switch at once, no pacing
                            src_q      <= req_cfg[`F_CFG_SRC];
                            cur_mode_q <= req_mode;
                            core_en_q  <= req_cfg[`F_CFG_CORE];
                            div_q      <= `DIV_UNITY;
                        end
                    end
                end
                ST_DOWN:
                begin
                    // current source rate and end value pace descent
                    if (step_due)
                    begin
                        // clamp at end divider of current source
                        if (down_sum >= {1'b0, end_q[src_q]})
                        begin
                            div_q   <= end_q[src_q];
                            state_q <= ST_SWITCH;
                        end
                        else
                        begin
                            div_q <= down_sum[15:0];
                            inc_q <= inc_q + change_q[src_q][`F_RATE];
                        end
                    end
                end
                ST_SWITCH:
                begin
                    // clock is now at its slow point; hand over the source
                    src_q      <= tgt_src_q;
                    cur_mode_q <= tgt_mode_q;
                    cur_lvl_q  <= tgt_lvl_q;
                    // cores come up while still slow
                    core_en_q  <= tgt_core_q;
                    if (tgt_src_q != `SRC_INTERNAL)
                    begin
                        state_q <= ST_UP;
                        div_q   <= start_q[tgt_src_q];
                        inc_q   <= change_q[tgt_src_q][`F_INIT];
                    end
                    else
                    begin
                        state_q <= ST_IDLE;
                        div_q   <= `DIV_UNITY;
                    end
                end
                ST_UP:
                begin
                    if (step_due)
                    begin
                        if (inc_q == 16'h0000 || {1'b0, div_q} <= up_floor)
                        begin
                            div_q   <= `DIV_UNITY;
                            state_q <= ST_IDLE;
                        end
                        else
                        begin
                            div_q <= div_q - inc_q;
                            if (inc_q > change_q[src_q][`F_RATE])
                                inc_q <= inc_q - change_q[src_q][`F_RATE];
                            else
                                inc_q <= 16'h0000;
                        end
                    end
                end
                default:
                begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    assign o_sys_src   = src_q;
    assign o_sys_div   = div_q;
    assign o_cur_mode  = cur_mode_q;
    assign o_core_en   = core_en_q;
    assign o_ramp_busy = (state_q != ST_IDLE);

    // ==========================================================
    // read path: data one cycle after the strobe, zero otherwise
    always @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_rdata <= 32'h0000_0000;
        end
        else if (i_rd)
        begin
            case (rd_grp)
                3'h1: o_rdata <= mode_cfg_q[rd_idx];
                3'h2: o_rdata <= change_q[rd_idx];
                3'h3: o_rdata <= {16'h0000, start_q[rd_idx]};
                3'h4: o_rdata <= {16'h0000, end_q[rd_idx]};
                default:
                begin
                    case (i_addr)
                        `A_STEP_DUR:  o_rdata <= {24'h000000, sdur_q};
                        `A_MODE_CTRL: o_rdata <= {30'h0, cur_mode_q};
                        `A_STATUS:    o_rdata <= {22'h0, core_en_q, state_q,
                                                  cur_lvl_q, src_q, cur_mode_q};
                        `A_CUR_DIV:   o_rdata <= {16'h0000, div_q};
                        `A_PROG_DONE: o_rdata <= {31'h0, prog_q};
                        default:      o_rdata <= 32'h0000_0000;
                    endcase
                end
            endcase
        end
        else
        begin
            o_rdata <= 32'h0000_0000;
        end
    end

endmodule // progressive_clock_ramp

// *** warm_reset_source.sv ***
// far-side model: the party that raises a non-power-on reset request
// assumes i_fire is a one-cycle pulse from the bench, one clock domain
`timescale 1ns/1ps

module warm_reset_source #(
    parameter HOLD = 4
) (
    input  wire  i_clk,
    input  wire  i_fire,
    output wire  o_warm_reset
);
    int cnt = 0;

    // ==========================================
    // request pulse
    // warm reset request
    always @(posedge i_clk)
    begin
        if (i_fire)
            cnt <= HOLD;
        else if (cnt != 0)
            cnt <= cnt - 1;
    end

    // held for several clocks so the two-flop sync cannot miss it
    assign o_warm_reset = (cnt != 0);
endmodule // warm_reset_source

// *** progressive_clock_ramp_checker.sv ***
// port-level timing relations of the progressive clock ramp
// assumes it is bound to the top module and sees its ports only
`timescale 1ns/1ps

module progressive_clock_ramp_checker (
    input wire        i_clk,
    input wire        i_rst,
    input wire [7:0]  i_addr,
    input wire        i_rd,
    input wire [31:0] o_rdata,
    input wire        i_warm_reset,
    input wire [1:0]  o_sys_src,
    input wire [15:0] o_sys_div,
    input wire [1:0]  o_cur_mode,
    input wire        o_core_en,
    input wire        o_ramp_busy
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    // ==========================================
    // assertions
    a_reset_values: assert property (
        $fell(i_rst) |-> o_sys_src == 2'h0 && o_sys_div == 16'h03e7 && !o_ramp_busy)
        else $error("reset did not land on the oscillator");
    a_idle_unity: assert property (
        !o_ramp_busy |-> o_sys_div == 16'h03e7)
        else $error("divider not unity while idle");
    a_div_floor: assert property (
        o_sys_div >= 16'h03e7)
        else $error("divider below unity");
    a_busy_src: assert property (
        o_ramp_busy && o_sys_div != 16'h03e7 |-> o_sys_src != 2'h0)
        else $error("ramp divider on the oscillator");
    a_step_hold: assert property (
        $changed(o_sys_div) && o_ramp_busy && $stable(o_sys_src)
        |=> $stable(o_sys_div) || $changed(o_sys_src) || $changed(o_cur_mode) || !o_ramp_busy)
        else $error("divider stepped on consecutive cycles");
    a_warm_starts: assert property (
        $rose(i_warm_reset) && !o_ramp_busy |-> ##[1:6] o_ramp_busy)
        else $error("warm reset did not start a switch");
    a_read_mode: assert property (
        $past(i_rd) && $past(i_addr) == 8'h04 |-> o_rdata == {30'h0, $past(o_cur_mode)})
        else $error("mode read mismatch");
    a_read_div: assert property (
        $past(i_rd) && $past(i_addr) == 8'h0c |-> o_rdata == {16'h0, $past(o_sys_div)})
        else $error("divider read mismatch");
    a_rdata_quiet: assert property (
        !$past(i_rd) |-> o_rdata == 32'h0)
        else $error("read data outside its cycle");
endmodule // progressive_clock_ramp_checker

bind progressive_clock_ramp progressive_clock_ramp_checker chk (
    .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_warm_reset(i_warm_reset), .o_sys_src(o_sys_src), .o_sys_div(o_sys_div),
    .o_cur_mode(o_cur_mode), .o_core_en(o_core_en), .o_ramp_busy(o_ramp_busy));

// *** testbench.sv ***
// self-checking bench for the progressive clock ramp
// assumes the register map of the defs header and a 50 MHz clock
`timescale 1ns/1ps
`include "progressive_clock_ramp_defs.vh"

module testbench;
    logic        i_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic [7:0]  i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0;
    logic        i_wr = 1'b0;
    logic        i_rd = 1'b0;
    logic        fire = 1'b0;
    wire  [31:0] o_rdata;
    wire         warm_reset;
    wire  [1:0]  o_sys_src;
    wire  [15:0] o_sys_div;
    wire  [1:0]  o_cur_mode;
    wire         o_core_en;
    wire         o_ramp_busy;
    int          bad_count = 0;
    int          total_checks = 0;
    int          cyc = 0;
    int          last_cyc = 0;
    int          gap_q[$];
    logic [15:0] seen_q[$];
    logic [15:0] exp_q[$];
    logic [15:0] last_div = 16'h03e7;
    logic [15:0] core_div = 16'h0;
    logic        last_core = 1'b0;
    logic        rec = 1'b0;
    logic        busy_seen = 1'b0;
    logic [31:0] v;
    logic [7:0]  ra[8] = '{8'h00, 8'h04, 8'h14, 8'h24, 8'h34, 8'h44, 8'h50, 8'h60};
    logic [31:0] rv[8] = '{32'h10, 32'h0, 32'h0, 32'h0, 32'h3e7, 32'h3e7, 32'h0, 32'h0};

    always #10 i_clk = ~i_clk;

    progressive_clock_ramp uut (
        .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
        .i_rd(i_rd), .o_rdata(o_rdata), .i_warm_reset(warm_reset), .o_sys_src(o_sys_src),
        .o_sys_div(o_sys_div), .o_cur_mode(o_cur_mode), .o_core_en(o_core_en),
        .o_ramp_busy(o_ramp_busy));
    warm_reset_source partner (.i_clk(i_clk), .i_fire(fire), .o_warm_reset(warm_reset));

    // ==========================================
    // divider monitor: records each new value and the clocks since the last
    always @(posedge i_clk)
    begin
        cyc = cyc + 1;
        if (rec && o_sys_div !== last_div)
        begin
            seen_q.push_back(o_sys_div);
            gap_q.push_back(cyc - last_cyc);
            last_cyc = cyc;
        end
        if (o_core_en === 1'b1 && last_core === 1'b0)
            core_div = o_sys_div;
        last_div = o_sys_div;
        last_core = o_core_en;
    end

    // ==========================================
    // tasks
    task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        @(negedge i_clk);
        d = o_rdata;
    endtask

    task automatic build_up(input int st, input int init, input int rate);
        int d;
        int i;
        d = st;
        i = init;
        exp_q.push_back(st[15:0]);
        while (i != 0 && d > i + 32'h3e7)
        begin
            d = d - i;
            i = (i > rate) ? i - rate : 0;
            exp_q.push_back(d[15:0]);
        end
        exp_q.push_back(16'h03e7);
    endtask

    task automatic build_down(input int en, input int rate);
        int d;
        int i;
        d = 32'h3e7;
        i = rate;
        while (d + i < en)
        begin
            d = d + i;
            i = i + rate;
            exp_q.push_back(d[15:0]);
        end
        exp_q.push_back(en[15:0]);
        exp_q.push_back(16'h03e7);
    endtask

    task automatic run(input logic [1:0] mode, input logic warm, input logic want);
        int n;
        seen_q.delete();
        gap_q.delete();
        busy_seen = 1'b0;
        rec = 1'b1;
        if (warm)
        begin
            @(posedge i_clk);
            fire <= 1'b1;
            @(posedge i_clk);
            fire <= 1'b0;
        end
        else
            wr(`A_MODE_CTRL, {30'h0, mode});
        n = 0;
        while (n < 3000 && (n < 12 || o_ramp_busy !== 1'b0))
        begin
            @(negedge i_clk);
            if (o_ramp_busy === 1'b1)
                busy_seen = 1'b1;
            n++;
        end
        // the monitor sees the last divider value only at the next rising edge
        @(negedge i_clk);
        rec = 1'b0;
        chk("ramp_done", 32'h0, {31'h0, o_ramp_busy});
        chk("ramp_busy", {31'h0, want}, {31'h0, busy_seen});
        chk("step_count", exp_q.size(), seen_q.size());
        foreach (exp_q[k])
            if (k < seen_q.size())
                chk("sys_div", {16'h0, exp_q[k]}, {16'h0, seen_q[k]});
        foreach (seen_q[k])
            if (k > 0 && seen_q[k] !== 16'h03e7)
                chk("step_gap", 32'h1, {31'h0, gap_q[k] >= 10 && gap_q[k] <= 14});
        chk("sys_mode", {30'h0, mode}, {30'h0, o_cur_mode});
        exp_q.delete();
    endtask

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ==========================================
    // sequence
    initial
    begin
        repeat (4) @(posedge i_clk);
        i_rst <= 1'b0;
        @(negedge i_clk);
        chk("src_after_reset", 32'h0, {30'h0, o_sys_src});
        chk("div_after_reset", 32'h3e7, {16'h0, o_sys_div});
        foreach (ra[k])
        begin
            rd(ra[k], v);
            chk("reset_reg", rv[k], v);
        end
        wr(`A_STEP_DUR, 32'h4);
        wr(`A_MODE_CFG_BASE + 8'h04, 32'h111);
        wr(`A_CHANGE_BASE + 8'h04, 32'h0064000a);
        wr(`A_START_BASE + 8'h04, 32'h577);
        wr(`A_END_BASE + 8'h04, 32'h513);
        rd(`A_CHANGE_BASE + 8'h04, v);
        chk("change_reg", 32'h0064000a, v);
        // caches would be set up here, clock still slow
        build_up(32'h577, 32'h64, 32'ha);
        run(2'h1, 1'b0, 1'b1);
        chk("core_on_slow", 32'h577, {16'h0, core_div});
        chk("src_up", 32'h1, {30'h0, o_sys_src});
        rd(`A_MODE_CTRL, v);
        chk("mode_read", 32'h1, v);
        rd(`A_STATUS, v);
        chk("status", 32'h215, v);
        rd(`A_CUR_DIV, v);
        chk("cur_div", 32'h3e7, v);
        build_down(32'h513, 32'ha);
        run(2'h0, 1'b0, 1'b1);
        chk("core_off", 32'h0, {31'h0, o_core_en});
        // level of the default mode changed first
        wr(`A_MODE_CFG_BASE, 32'h2);
        run(2'h0, 1'b0, 1'b1);
        run(2'h0, 1'b0, 1'b0);
        wr(`A_PROG_DONE, 32'h1);
        rd(`A_PROG_DONE, v);
        chk("prog_flag", 32'h1, v);
        build_up(32'h577, 32'h64, 32'ha);
        run(2'h1, 1'b0, 1'b1);
        build_down(32'h513, 32'ha);
        run(2'h0, 1'b1, 1'b1);
        chk("src_warm", 32'h0, {30'h0, o_sys_src});
        chk("core_warm", 32'h0, {31'h0, o_core_en});
        print_verdict();
    end

    // a ramp that never ends would hang the run
    initial
    begin
        repeat (20000) @(posedge i_clk);
        bad_count++;
        print_verdict();
    end
endmodule // testbench
